// ---- design/frpp_defines.vh ----
// Constants for the flash row programming host: device map, timing and register offsets
`ifndef FRPP_DEFINES_VH
`define FRPP_DEFINES_VH

// Device map
`define FRPP_ADDR_CTRL        16'hFE08
`define FRPP_ADDR_PROT        16'hFF7E
`define FRPP_ADDR_WDOG        16'hFFFF
`define FRPP_USER_LO          16'hC000
`define FRPP_USER_HI          16'hFDFF
`define FRPP_VEC_LO           16'hFFDC
`define FRPP_RSV_LO           16'hFFD4
`define FRPP_RSV_HI           16'hFFDF

// Control register bit positions in the device
`define FRPP_CTRL_PGM_BIT     0
`define FRPP_CTRL_ERASE_BIT   1
`define FRPP_CTRL_MASS_BIT    2
`define FRPP_CTRL_HIGH_VOLTAGE_ENABLE_BIT    3

// Protect byte values
`define FRPP_PROT_OPEN        8'hFF
`define FRPP_PROT_VECTORS     8'hFE
`define FRPP_ERASED           8'hFF

// Row geometry
`define FRPP_ROW_BYTES        32
`define FRPP_ROW_SHIFT        5

// Timing: figures in ns, counts in 40 ns cycles
`define FRPP_CLK_NS           40
`define FRPP_T_NVS_NS         10000
`define FRPP_T_PGS_NS         5000
`define FRPP_T_PROG_NS        30000
`define FRPP_T_NVH_NS         5000
`define FRPP_T_RCV_NS         1000
`define FRPP_CYC_MIN(ns)      (((ns) + `FRPP_CLK_NS - 1) / `FRPP_CLK_NS)

// Wishbone register offsets (byte addresses)
`define FRPP_REG_CMD          8'h00
`define FRPP_REG_ROW          8'h04
`define FRPP_REG_MASK         8'h08
`define FRPP_REG_STATUS       8'h0C
`define FRPP_REG_DATA_BASE    8'h40
`define FRPP_REG_DATA_LAST    8'h5C

// Command bits
`define FRPP_CMD_START_BIT    0
`define FRPP_CMD_MONFAIL_BIT  1

// Status bits
`define FRPP_ST_BUSY_BIT      0
`define FRPP_ST_DONE_BIT      1
`define FRPP_ST_EPROT_BIT     2
`define FRPP_ST_ENOTFF_BIT    3
`define FRPP_ST_EADDR_BIT     4
`define FRPP_ST_PROT_LSB      8

`endif

// ---- design/frpp_row_buffer.v ----
// Row data buffer: byte-lane word writes, registered byte read
`timescale 1ns/1ns
`default_nettype none
module frpp_row_buffer #(
   parameter WORDS = 8,
   parameter AW    = 3
) (
   input  wire          sys_clk,
   input  wire          wrEn,
   input  wire [AW-1:0] wrWord,
   input  wire [3:0]    wrSel,
   input  wire [31:0]   wrData,
   input  wire [AW+1:0] rdByte,
   output reg  [7:0]    rdData
);
   reg [31:0] mem [0:WORDS-1];
   integer    i;

   // Byte-lane write
   always @(posedge sys_clk) begin
      for (i = 0; i < 4; i = i + 1) begin
         if (wrEn && wrSel[i]) begin
            mem[wrWord][i*8 +: 8] <= wrData[i*8 +: 8];
         end
      end
   end

   // Registered read; data lags the index by one cycle
   always @(posedge sys_clk) begin
      rdData <= mem[rdByte[AW+1:2]][rdByte[1:0]*8 +: 8];
   end
endmodule // frpp_row_buffer
`default_nettype wire

// ---- design/frpp_delay_timer.v ----
// Down-counting delay timer with a level done flag
`timescale 1ns/1ns
`default_nettype none
module frpp_delay_timer #(
   parameter W = 16
) (
   input  wire         sys_clk,
   input  wire         sys_rst,
   input  wire         load,
   input  wire [W-1:0] count,
   output wire         expired
);
   reg [W-1:0] cnt_q;

   // Load wins over counting so a new wait always starts fresh
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_q <= {W{1'b0}};
      end else if (load) begin
         cnt_q <= count;
      end else if (cnt_q != {W{1'b0}}) begin
         cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign expired = (cnt_q == {W{1'b0}}) && !load;
endmodule // frpp_delay_timer
`default_nettype wire

// ---- design/frpp_row_programmer.v ----
// Host sequencer that programs one flash row through the device's control registers
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "frpp_defines.vh"
module frpp_row_programmer #(
   parameter TW       = 16,
   parameter NVS_CYC  = `FRPP_CYC_MIN(`FRPP_T_NVS_NS),
   parameter PGS_CYC  = `FRPP_CYC_MIN(`FRPP_T_PGS_NS),
   parameter PROG_CYC = `FRPP_CYC_MIN(`FRPP_T_PROG_NS),
   parameter NVH_CYC  = `FRPP_CYC_MIN(`FRPP_T_NVH_NS),
   parameter RCV_CYC  = `FRPP_CYC_MIN(`FRPP_T_RCV_NS)
) (
   input  wire        sys_clk,
   input  wire        sys_rst,
   // Wishbone classic slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Device bus, synchronous to sys_clk
   output reg  [15:0] devAddr,
   output reg  [7:0]  devWrData,
   output reg         devWrEn,
   output reg         devRdEn,
   input  wire [7:0]  devRdData,
   // Test high voltage sense from the pin
   input  wire        testHighVoltage
);
   // States
   localparam [4:0] S_IDLE    = 5'h00;
   localparam [4:0] S_PRE_SEL = 5'h01;
   localparam [4:0] S_PRE_RD  = 5'h02;
   localparam [4:0] S_PRE_CHK = 5'h03;
   localparam [4:0] S_SET_PGM = 5'h04;
   localparam [4:0] S_RD_PROT = 5'h05;
   localparam [4:0] S_CHK_PRT = 5'h06;
   localparam [4:0] S_DUMMY   = 5'h07;
   localparam [4:0] S_W_NVS   = 5'h08;
   localparam [4:0] S_SET_HV  = 5'h09;
   localparam [4:0] S_W_PGS   = 5'h0A;
   localparam [4:0] S_SEL     = 5'h0B;
   localparam [4:0] S_WR_BYTE = 5'h0C;
   localparam [4:0] S_W_PROG  = 5'h0D;
   localparam [4:0] S_CLR_PGM = 5'h0E;
   localparam [4:0] S_W_NVH   = 5'h0F;
   localparam [4:0] S_CLR_HV  = 5'h10;
   localparam [4:0] S_W_RCV   = 5'h11;
   localparam [4:0] S_FINISH  = 5'h12;

   localparam [7:0] CTRL_PGM  = 8'h01 << `FRPP_CTRL_PGM_BIT;
   localparam [7:0] CTRL_HIGH_VOLTAGE_ENABLE = 8'h01 << `FRPP_CTRL_HIGH_VOLTAGE_ENABLE_BIT;

   // Byte may be targeted: array, protect byte or vectors, never reserved or watchdog
   function isArrayAddr;
      input [15:0] a;
      begin
         isArrayAddr = ((a >= `FRPP_USER_LO) && (a <= `FRPP_USER_HI)) ||
                       (a == `FRPP_ADDR_PROT) ||
                       ((a >= `FRPP_VEC_LO) && (a != `FRPP_ADDR_WDOG)) ;
      end
   endfunction

   // Protect start address from the protect bits
   function [15:0] protStart;
      input [7:0] p;
      begin
         protStart = {2'b11, p, 6'b000000};
      end
   endfunction

   reg  [4:0]  state_q;
   reg  [4:0]  idx_q;
   reg  [15:0] row_q;
   reg  [31:0] mask_q;
   reg         monFail_q;
   reg  [7:0]  prot_q;
   reg         busy_q;
   reg         done_q;
   reg         errProt_q;
   reg         errNotFf_q;
   reg         errAddr_q;
   reg         tstMeta_q;
   reg         tstSync_q;
   reg         tmrLoad;
   reg  [TW-1:0] tmrCount;
   wire        tmrExpired;
   wire [7:0]  bufData;
   wire [15:0] byteAddr;
   wire        wbReq;
   wire        startCmd;
   wire        bufWrite;
   wire        byteWanted;
   wire        rowProtected;

   assign wbReq    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign startCmd = wbReq && wb_we_i && (wb_adr_i == `FRPP_REG_CMD) &&
                     wb_sel_i[0] && wb_dat_i[`FRPP_CMD_START_BIT] && !busy_q;
   // Buffer is frozen while a row is in flight
   assign bufWrite = wbReq && wb_we_i && !busy_q &&
                     (wb_adr_i >= `FRPP_REG_DATA_BASE) &&
                     (wb_adr_i <= `FRPP_REG_DATA_LAST) && (wb_adr_i[1:0] == 2'b00);
   assign byteAddr   = {row_q[15:`FRPP_ROW_SHIFT], idx_q};
   assign byteWanted = mask_q[idx_q] && isArrayAddr(byteAddr);

   // Range check against the latched protect byte; test voltage bypasses it
   assign rowProtected = !tstSync_q && (prot_q != `FRPP_PROT_OPEN) &&
                         (({row_q[15:`FRPP_ROW_SHIFT], 5'h1F} >= protStart(prot_q)) ||
                          ((row_q[15:`FRPP_ROW_SHIFT] ==
                            `FRPP_ADDR_PROT >> `FRPP_ROW_SHIFT) &&
                           (prot_q != `FRPP_PROT_VECTORS)));

   frpp_row_buffer #(
      .WORDS (8),
      .AW    (3)
   ) u_buf (
      .sys_clk (sys_clk),
      .wrEn    (bufWrite),
      .wrWord  (wb_adr_i[4:2]),
      .wrSel   (wb_sel_i),
      .wrData  (wb_dat_i),
      .rdByte  (idx_q),
      .rdData  (bufData)
   );

   frpp_delay_timer #(
      .W (TW)
   ) u_tmr (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .load    (tmrLoad),
      .count   (tmrCount),
      .expired (tmrExpired)
   );

   // Pin synchroniser for the test voltage sense
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         tstMeta_q <= 1'b0;
         tstSync_q <= 1'b0;
      end else begin
         tstMeta_q <= testHighVoltage;
         tstSync_q <= tstMeta_q;
      end
   end

   // Wishbone slave: ack one cycle after the request, unmapped reads as zero
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wbReq;
         wb_dat_o <= 32'h00000000;
         if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
               `FRPP_REG_CMD: begin
                  wb_dat_o <= {30'h00000000, monFail_q, 1'b0};
               end
               `FRPP_REG_ROW: begin
                  wb_dat_o <= {16'h0000, row_q};
               end
               `FRPP_REG_MASK: begin
                  wb_dat_o <= mask_q;
               end
               `FRPP_REG_STATUS: begin
                  wb_dat_o <= {16'h0000, prot_q, 3'b000, errAddr_q, errNotFf_q,
                               errProt_q, done_q, busy_q};
               end
               default: begin
                  wb_dat_o <= 32'h00000000;
               end
            endcase
         end
      end
   end

   // Software-written setup, locked while busy
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         row_q     <= 16'h0000;
         mask_q    <= 32'h00000000;
         monFail_q <= 1'b0;
      end else if (wbReq && wb_we_i && !busy_q) begin
         if (wb_adr_i == `FRPP_REG_ROW) begin
            if (wb_sel_i[0]) row_q[7:0]  <= {wb_dat_i[7:5], 5'h00};
            if (wb_sel_i[1]) row_q[15:8] <= wb_dat_i[15:8];
         end
         if (wb_adr_i == `FRPP_REG_MASK) begin
            mask_q <= wb_dat_i;
         end
         if ((wb_adr_i == `FRPP_REG_CMD) && wb_sel_i[0]) begin
            monFail_q <= wb_dat_i[`FRPP_CMD_MONFAIL_BIT];
         end
      end
   end

   // Row sequencer; only hardware sets the sticky flags, start clears them
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q    <= S_IDLE;
         idx_q      <= 5'h00;
         prot_q     <= 8'h00;
         busy_q     <= 1'b0;
         done_q     <= 1'b0;
         errProt_q  <= 1'b0;
         errNotFf_q <= 1'b0;
         errAddr_q  <= 1'b0;
         devAddr    <= 16'h0000;
         devWrData  <= 8'h00;
         devWrEn    <= 1'b0;
         devRdEn    <= 1'b0;
         tmrLoad    <= 1'b0;
         tmrCount   <= {TW{1'b0}};
      end else begin
         devWrEn <= 1'b0;
         devRdEn <= 1'b0;
         tmrLoad <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (startCmd) begin
                  busy_q     <= 1'b1;
                  done_q     <= 1'b0;
                  errProt_q  <= 1'b0;
                  errNotFf_q <= 1'b0;
                  errAddr_q  <= 1'b0;
                  idx_q      <= 5'h00;
                  state_q    <= S_PRE_SEL;
               end
            end
            // Erased check before any high voltage
            S_PRE_SEL: begin
               if (byteWanted) begin
                  devAddr <= byteAddr;
                  devRdEn <= 1'b1;
                  state_q <= S_PRE_RD;
               end else begin
                  if (mask_q[idx_q]) errAddr_q <= 1'b1;
                  state_q <= S_PRE_CHK;
               end
            end
            S_PRE_RD: begin
               state_q <= S_PRE_CHK;
            end
            S_PRE_CHK: begin
               if (byteWanted && (devRdData != `FRPP_ERASED)) begin
                  errNotFf_q <= 1'b1;
               end
               if (idx_q == 5'h1F) begin
                  idx_q   <= 5'h00;
                  state_q <= (errNotFf_q || (byteWanted && devRdData != `FRPP_ERASED))
                             ? S_FINISH : S_SET_PGM;
               end else begin
                  idx_q   <= idx_q + 5'h01;
                  state_q <= S_PRE_SEL;
               end
            end
            // Program select alone; erase bits always zero
            S_SET_PGM: begin
               devAddr   <= `FRPP_ADDR_CTRL;
               devWrData <= CTRL_PGM;
               devWrEn   <= 1'b1;
               state_q   <= S_RD_PROT;
            end
            S_RD_PROT: begin
               devAddr <= `FRPP_ADDR_PROT;
               devRdEn <= 1'b1;
               state_q <= S_CHK_PRT;
            end
            // Read data stands only in the cycle after the strobe
            S_CHK_PRT: begin
               if (!devRdEn) begin
                  prot_q  <= devRdData;
                  state_q <= S_DUMMY;
               end
            end
            S_DUMMY: begin
               if (rowProtected) begin
                  // Device would refuse HV; back out cleanly instead
                  errProt_q <= 1'b1;
                  state_q   <= S_CLR_PGM;
               end else begin
                  devAddr   <= monFail_q ? `FRPP_ADDR_PROT : row_q;
                  devWrData <= 8'h00;
                  devWrEn   <= 1'b1;
                  tmrLoad   <= 1'b1;
                  tmrCount  <= NVS_CYC[TW-1:0];
                  state_q   <= S_W_NVS;
               end
            end
            S_W_NVS: begin
               if (tmrExpired) state_q <= S_SET_HV;
            end
            S_SET_HV: begin
               devAddr   <= `FRPP_ADDR_CTRL;
               devWrData <= CTRL_PGM | CTRL_HIGH_VOLTAGE_ENABLE;
               devWrEn   <= 1'b1;
               tmrLoad   <= 1'b1;
               tmrCount  <= PGS_CYC[TW-1:0];
               state_q   <= S_W_PGS;
            end
            S_W_PGS: begin
               if (tmrExpired) state_q <= S_SEL;
            end
            // Buffer byte for idx_q is valid in the next cycle
            S_SEL: begin
               state_q <= byteWanted ? S_WR_BYTE : S_W_PROG;
            end
            S_WR_BYTE: begin
               devAddr   <= byteAddr;
               devWrData <= bufData;
               devWrEn   <= 1'b1;
               tmrLoad   <= 1'b1;
               tmrCount  <= PROG_CYC[TW-1:0];
               state_q   <= S_W_PROG;
            end
            S_W_PROG: begin
               if (tmrExpired) begin
                  if (idx_q == 5'h1F) begin
                     state_q <= S_CLR_PGM;
                  end else begin
                     idx_q   <= idx_q + 5'h01;
                     state_q <= S_SEL;
                  end
               end
            end
            // Leaving program mode with HV still on; after a protect refusal all bits are cleared
            S_CLR_PGM: begin
               devAddr   <= `FRPP_ADDR_CTRL;
               devWrData <= errProt_q ? 8'h00 : CTRL_HIGH_VOLTAGE_ENABLE;
               devWrEn   <= 1'b1;
               tmrLoad   <= 1'b1;
               tmrCount  <= NVH_CYC[TW-1:0];
               state_q   <= S_W_NVH;
            end
            S_W_NVH: begin
               if (tmrExpired) state_q <= S_CLR_HV;
            end
            S_CLR_HV: begin
               devAddr   <= `FRPP_ADDR_CTRL;
               devWrData <= 8'h00;
               devWrEn   <= 1'b1;
               tmrLoad   <= 1'b1;
               tmrCount  <= RCV_CYC[TW-1:0];
               state_q   <= S_W_RCV;
            end
            S_W_RCV: begin
               if (tmrExpired) state_q <= S_FINISH;
            end
            S_FINISH: begin
               busy_q  <= 1'b0;
               done_q  <= 1'b1;
               idx_q   <= 5'h00;
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // frpp_row_programmer
`default_nettype wire

// ---- tb/frpp_prog_monitor.sv ----
// Concurrent checks on the host's bus and device-link ports
`timescale 1ns/1ns
`default_nettype none
module frpp_prog_monitor #(
   parameter NVS_CYC  = 250,
   parameter PGS_CYC  = 125,
   parameter PROG_CYC = 750,
   parameter NVH_CYC  = 125
) (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [15:0] devAddr,
   input wire logic [7:0]  devWrData,
   input wire logic        devWrEn,
   input wire logic        devRdEn
);
   logic [15:0] gap_q;
   logic        pgm_q, hv_q, rd_q, sel_q, byte_q, ctl, hvSet;
   assign ctl   = devWrEn && devAddr == 16'hFE08;
   assign hvSet = ctl && devWrData[3] && !hv_q;
   // Shadow of the device's control state; gap counts idle cycles since the last access
   always @(posedge sys_clk) begin
      if (sys_rst || ctl && devWrData[1:0] == 2'b00) begin
         rd_q  <= 1'b0;
         sel_q <= 1'b0;
      end else begin
         rd_q  <= rd_q || devRdEn && devAddr == 16'hFF7E && pgm_q;
         sel_q <= sel_q || devWrEn && !ctl && pgm_q && !hv_q;
      end
      if (sys_rst) begin
         pgm_q <= 1'b0;
         hv_q  <= 1'b0;
      end else if (ctl) begin
         pgm_q <= devWrData[0];
         hv_q  <= devWrData[3];
      end
      byte_q <= !sys_rst && !hvSet && (byte_q || devWrEn && !ctl && hv_q);
      gap_q  <= (sys_rst || devWrEn || devRdEn) ? 16'h0000 : gap_q + {15'h0, gap_q != 16'hFFFF};
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_wr_pulse: assert property (devWrEn |=> !devWrEn)
      else $error("device write strobe longer than one cycle");
   chk_rd_pulse: assert property (devRdEn |=> !devRdEn)
      else $error("device read strobe longer than one cycle");
   chk_select_interlock: assert property (ctl |-> devWrData[1:0] != 2'b11)
      else $error("program and erase select written together");
   chk_hv_order: assert property (hvSet |-> pgm_q && rd_q && sel_q)
      else $error("high voltage set out of step order");
   chk_setup_wait: assert property (hvSet |-> gap_q >= NVS_CYC - 1)
      else $error("high voltage set too soon after row select");
   chk_byte_gap: assert property (devWrEn && hv_q && pgm_q |->
      gap_q >= (byte_q ? PROG_CYC : PGS_CYC) - 1)
      else $error("byte write or select clear too soon");
   chk_hold_wait: assert property (ctl && hv_q && !pgm_q |-> gap_q >= NVH_CYC - 1)
      else $error("high voltage cleared too soon after select clear");
   chk_no_wdog: assert property (devWrEn && hv_q |-> devAddr != 16'hFFFF)
      else $error("top address written with high voltage on");
   chk_no_reserved: assert property (devWrEn |-> !(devAddr >= 16'hFFD4 && devAddr <= 16'hFFDB))
      else $error("write to reserved location");
endmodule // frpp_prog_monitor

bind frpp_row_programmer frpp_prog_monitor #(.NVS_CYC(NVS_CYC), .PGS_CYC(PGS_CYC),
   .PROG_CYC(PROG_CYC), .NVH_CYC(NVH_CYC)) mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .devAddr(devAddr),
   .devWrData(devWrData), .devWrEn(devWrEn), .devRdEn(devRdEn));
`default_nettype wire

// ---- tb/frpp_flash_model.sv ----
// Behavioural flash device: array, control register and protect byte
`timescale 1ns/1ns
`default_nettype none
module frpp_flash_model (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] devAddr,
   input  wire logic [7:0]  devWrData,
   input  wire logic        devWrEn,
   input  wire logic        devRdEn,
   output var  logic [7:0]  devRdData,
   input  wire logic        testHighVoltage
);
   logic [7:0]  mem [0:16383];   // Array at C000 up, protect byte inside it
   logic [3:0]  ctrl_q;
   logic [10:0] row_q;
   logic [7:0]  pByte;
   logic        protRd_q, rowSel_q, wild_q, refused_q, badProg_q, prot, hvOk;
   initial devRdData = 8'h5A;
   assign pByte = mem[14'h3F7E];
   // Region from start address to the top; all ones opens everything, test voltage bypasses
   assign prot = pByte != 8'hFF && {row_q, 5'h00} >= {2'b11, pByte, 6'h00} && !testHighVoltage;
   // Mass erase refused once anything is protected
   assign hvOk = ctrl_q[3] || devWrData[1:0] != 2'b00 && protRd_q && rowSel_q && !prot
                 && !(devWrData[2] && pByte != 8'hFF);
   // Read data is valid only the cycle after a read, otherwise it keeps toggling
   always @(posedge sys_clk) begin
      devRdData <= devRdEn ? (devAddr == 16'hFE08 ? {4'h0, ctrl_q} : mem[devAddr[13:0]]) : ~devRdData;
      if (devRdEn && devAddr == 16'hFF7E && ctrl_q[1:0] != 2'b00)
         protRd_q <= 1'b1;
      if (sys_rst) begin
         ctrl_q    <= 4'h0;
         protRd_q  <= 1'b0;
         rowSel_q  <= 1'b0;
         refused_q <= 1'b0;
         badProg_q <= 1'b0;
      end else if (devWrEn && devAddr == 16'hFE08) begin
         if (devWrData[1:0] != 2'b11) begin
            ctrl_q    <= {devWrData[3] && hvOk, devWrData[2:0]};
            refused_q <= refused_q || devWrData[3] && !hvOk;
         end
         if (devWrData[1:0] == 2'b00) begin
            protRd_q <= 1'b0;
            rowSel_q <= 1'b0;
         end
      end else if (devWrEn && ctrl_q[0] && !ctrl_q[3] && !rowSel_q) begin
         rowSel_q <= 1'b1;
         row_q    <= devAddr[15:5];
         wild_q   <= devAddr == 16'hFF7E;
      end else if (devWrEn && ctrl_q[0] && ctrl_q[3] && (wild_q || devAddr[15:5] == row_q)) begin
         mem[devAddr[13:0]] <= mem[devAddr[13:0]] & devWrData;
         badProg_q <= badProg_q || mem[devAddr[13:0]] != 8'hFF || devAddr == 16'hFFFF;
      end
   end
endmodule // frpp_flash_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench: random row programs with protection and address corners
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        sysClk = 1'b0, sysRst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic        testHv = 1'b0, wbAck, devWrEn, devRdEn;
   logic [3:0]  wbSel = 4'hF;
   logic [7:0]  wbAdr = 8'h00, devWrData, devRdData;
   logic [31:0] wbDat = 32'h0, wbDatO, seed = 32'h7434, q;
   logic [15:0] devAddr;
   int          n_mismatch = 0, compares = 0;
   always #20 sysClk = ~sysClk;
   frpp_row_programmer #(.NVS_CYC(8), .PGS_CYC(4), .PROG_CYC(6), .NVH_CYC(5), .RCV_CYC(4)) uut (
      .sys_clk(sysClk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .devAddr(devAddr), .devWrData(devWrData), .devWrEn(devWrEn), .devRdEn(devRdEn),
      .devRdData(devRdData), .testHighVoltage(testHv));
   frpp_flash_model dev (.sys_clk(sysClk), .sys_rst(sysRst), .devAddr(devAddr),
      .devWrData(devWrData), .devWrEn(devWrEn), .devRdEn(devRdEn), .devRdData(devRdData),
      .testHighVoltage(testHv));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Array bytes that the host may legally target
   function automatic logic legal(input logic [15:0] a);
      return (a >= 16'hC000 && a <= 16'hFDFF) || (a >= 16'hFFDC && a <= 16'hFFFE) || a == 16'hFF7E;
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Classic single cycle; request held until ack is sampled, then dropped for a cycle
   task automatic wbXfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      begin
         n = 0;
         wbAdr <= a;
         wbWe  <= w;
         wbDat <= d;
         wbCyc <= 1'b1;
         wbStb <= 1'b1;
         do begin
            @(posedge sysClk);
            n++;
         end while (wbAck !== 1'b1 && n < 50);
         q = wbDatO;
         check("wb ack", wbAck, 1'b1);
         wbCyc <= 1'b0;
         wbStb <= 1'b0;
         @(posedge sysClk);
      end
   endtask
   // One row program; a zero mask means a random one, dirty names a pre-programmed byte
   task automatic runCase(input logic [15:0] row, input logic [31:0] mk, input logic [7:0] p,
                          input logic tv, input logic mon, input int dirty);
      logic [255:0] dat;
      logic [15:0]  a;
      logic [7:0]   e;
      logic         prot, nff, bad;
      logic [31:0]  m;
      int           n;
      begin
         if (mk == 32'h0)
            mk = rnd();
         dev.mem[14'h3F7E] = p;
         testHv <= tv;
         nff = 1'b0;
         bad = 1'b0;
         prot = p != 8'hFF && row >= {2'b11, p, 6'h00} && !tv;
         for (int k = 0; k < 32; k++) begin
            a = row + 16'(k);
            dev.mem[a[13:0]] = (k == dirty) ? 8'h00 : 8'hFF;
            nff |= mk[k] && legal(a) && k == dirty;
            bad |= mk[k] && !legal(a);
         end
         for (int w = 0; w < 8; w++) begin
            dat[32*w +: 32] = rnd();
            wbXfer(8'h40 + 8'(4 * w), 1'b1, dat[32*w +: 32]);
         end
         wbXfer(8'h04, 1'b1, {16'h0, row});
         wbXfer(8'h08, 1'b1, mk);
         wbXfer(8'h00, 1'b1, {30'h0, mon, 1'b1});
         wbXfer(8'h08, 1'b1, 32'h0); // Ignored while busy
         n = 0;
         do begin
            wbXfer(8'h0C, 1'b0, 32'h0);
            n++;
         end while (q[0] !== 1'b0 && n < 3000);
         // A dirty row stops before the protect read, so only the low flags are defined
         m = nff ? 32'h1F : 32'hFFFFFFFF;
         check("status", q & m,
               {16'h0, p, 3'b000, bad, nff, prot && !nff, 2'b10} & m);
         wbXfer(8'h08, 1'b0, 32'h0);
         check("mask kept", q, mk);
         for (int k = 0; k < 32; k++) begin
            a = row + 16'(k);
            e = (mk[k] && legal(a) && !prot && !nff) ? dat[8*k +: 8] : ((k == dirty) ? 8'h00 : 8'hFF);
            check("row byte", {24'h0, dev.mem[a[13:0]]}, {24'h0, e});
         end
         check("device flags", {30'h0, dev.refused_q, dev.badProg_q}, 32'h0);
         $display("case row %h protect %h done", row, p);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Watchdog sized well above the expected run
   initial begin
      repeat (40000) @(posedge sysClk);
      n_mismatch++;
      tally_and_finish();
   end
   // Main sequence: register checks, then corner and random rows
   initial begin
      repeat (20) @(posedge sysClk);
      sysRst <= 1'b0;
      @(posedge sysClk);
      wbXfer(8'h20, 1'b1, 32'hFFFFFFFF);
      wbXfer(8'h20, 1'b0, 32'h0);
      check("unmapped read", q, 32'h0);
      wbXfer(8'h0C, 1'b0, 32'h0);
      check("status after reset", q, 32'h0);
      wbXfer(8'h44, 1'b0, 32'h0);
      check("data read", q, 32'h0);
      wbSel <= 4'h2;
      wbXfer(8'h04, 1'b1, 32'h0000ABCD);
      wbSel <= 4'hF;
      wbXfer(8'h04, 1'b0, 32'h0);
      check("row lanes", q, 32'h0000AB00);
      $display("register checks done");
      runCase(16'hC000, 32'h0, 8'hFF, 1'b0, 1'b0, 32);
      runCase(16'hFDE0, 32'hFFFFFFFF, 8'hFE, 1'b0, 1'b0, 32);
      runCase(16'hFFE0, 32'h0000FFFF, 8'hFE, 1'b0, 1'b0, 32);
      runCase(16'hC040, 32'h0, 8'h01, 1'b0, 1'b0, 32);
      runCase(16'hC020, 32'h0, 8'h01, 1'b0, 1'b0, 32);
      runCase(16'hC000, 32'h0, 8'h00, 1'b0, 1'b0, 32);
      runCase(16'hC000, 32'h0, 8'h00, 1'b1, 1'b0, 32);
      runCase(16'hC0A0, 32'hFFFFFFFF, 8'hFF, 1'b0, 1'b0, 5);
      runCase(16'hFFE0, 32'hFFFFFFFF, 8'hFF, 1'b0, 1'b0, 32);
      runCase(16'hFFC0, 32'hFFF00000, 8'hFF, 1'b0, 1'b0, 32);
      runCase(16'hC100, 32'h0, 8'hFF, 1'b0, 1'b1, 32);
      runCase(16'hC3E0, 32'h80000001, 8'hFF, 1'b0, 1'b0, 32);
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
